// >>> sfo_flag_ctl.sv
// Purpose: opcode acceptance per protocol and the operation flag byte
// Assumes: core events arrive on sys_clk; pins are sampled on spi_clk rise
// Notes: flags reach the link through a req/ack handshake of snapshots
// Summary of operation
// - ready bit low while write cycle busy
// - erase suspend bit follows suspend state
// - erase failure sets bit 5
// - program failure, or accel 0-to-1 with a pattern multiple of 64 bits, sets bit 4
// - invalid accelerator supply during operation sets bit 3
// - program suspend bit follows suspend state
// - protected sector or locked area sets bit 1
// - bit 0 shows four byte addressing
// - all flags volatile, returned by flag read
// - status bits follow device state by themselves
// - error bits sticky until clear command
// - ready bit is inverse of write in progress
// - identification opcodes gated by protocol
// - dual fast reads refused in quad protocol
// - quad fast reads refused in dual protocol
// - rate doubled dual reads refused in quad
// - rate doubled quad reads refused in dual
// - four byte dual reads refused in quad
// - four byte quad reads refused in dual
// - 70h reads flags, 50h clears errors
`default_nettype none
module sfo_flag_ctl import sfo_pkg::*; (
  input wire logic sys_clk, // core clock
  input wire logic rst, // sync reset, high
  input wire logic wip, // write cycle in progress
  input wire logic erase_susp, // erase suspended or pending
  input wire logic prog_susp, // program suspended or pending
  input wire logic addr4_en, // four byte addressing
  input wire logic [1:0] proto_sel, // active protocol
  input wire logic erase_fail, // erase failed, pulse
  input wire logic prog_fail, // program failed, pulse
  input wire logic prog_zero_to_one, // program tried 0 to 1, pulse
  input wire logic accel_high_voltage, // accelerator at high level
  input wire logic pattern_mult64, // pattern multiple of 64 bits
  input wire logic vpp_invalid, // accelerator supply invalid
  input wire logic prot_sector_hit, // protected sector hit, pulse
  input wire logic otp_locked_hit, // locked otp write, pulse
  output logic [7:0] flags, // operation flag byte
  output logic op_valid, // accepted opcode, pulse
  output logic [7:0] op_code, // last accepted opcode
  input wire logic spi_clk, // link clock
  input wire logic cs_n, // chip select, low active
  input wire logic [3:0] dq_in, // data lines in
  output logic [3:0] dq_out, // data lines out
  output logic [3:0] dq_oe // data line enables
);

  typedef struct packed {
    logic [7:0] flags;
    logic [9:0] snap;
    logic req;
    logic ack_s1;
    logic ack_s2;
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    logic [7:0] op_code;
    logic op_valid;
  } sfo_core_t;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic req_s1;
    logic req_s2;
    logic ack;
    logic [1:0] proto;
    logic [7:0] flags;
    logic tog;
    logic [7:0] op;
  } sfo_lhs_t;

  typedef struct packed {
    sfo_phase_t phase;
    logic [2:0] cnt;
    logic [7:0] sr;
    logic [3:0] dout;
    logic [3:0] oe;
  } sfo_lfr_t;

  localparam sfo_lfr_t FR_RST = '{phase: PH_OP, default: '0};

  sfo_core_t cq, cd;
  sfo_lhs_t hq, hd;
  sfo_lfr_t fq, fd;
  logic clr_now;
  logic op_last;
  logic op_acc;
  logic [7:0] op_new;
  sfo_proto_t pr;

  function automatic logic sfo_op_ok(input logic [7:0] op, input sfo_proto_t p);
    logic ext;
    logic dual;
    logic quad;
    logic ok;
    ext = (p == PR_EXT);
    dual = (p == PR_DUAL);
    quad = !ext && !dual;
    unique case (op)
      OP_ID_A, OP_ID_B: ok = ext;
      OP_ID_MIO: ok = !ext;
      OP_READ: ok = ext;
      OP_DOFR, OP_DIOFR: ok = !quad;
      OP_QOFR, OP_QIOFR: ok = !dual;
      OP_DTR_FR: ok = 1'h1;
      OP_DTR_DOFR, OP_DTR_DIOFR: ok = !quad;
      OP_DTR_QOFR, OP_DTR_QIOFR: ok = !dual;
      OP_4B_DOFR, OP_4B_DIOFR: ok = !quad;
      OP_4B_QOFR, OP_4B_QIOFR: ok = !dual;
      OP_DPROG, OP_XDPROG: ok = !quad;
      OP_QPROG, OP_4B_QPROG, OP_XQPROG: ok = !dual;
      default: ok = 1'h1;
    endcase
    return ok;
  endfunction : sfo_op_ok

  // units per byte minus one: 8, 4 or 2 clocks per byte
  function automatic logic [2:0] sfo_last(input sfo_proto_t p);
    unique case (p)
      PR_EXT: return 3'h7;
      PR_DUAL: return 3'h3;
      default: return 3'h1;
    endcase
  endfunction : sfo_last

  function automatic logic [7:0] sfo_shin(input logic [7:0] s, input logic [3:0] d,
                                           input sfo_proto_t p);
    unique case (p)
      PR_EXT: return {s[6:0], d[0]};
      PR_DUAL: return {s[5:0], d[1:0]};
      default: return {s[3:0], d};
    endcase
  endfunction : sfo_shin

  function automatic logic [7:0] sfo_shl(input logic [7:0] s, input sfo_proto_t p);
    unique case (p)
      PR_EXT: return {s[6:0], 1'h0};
      PR_DUAL: return {s[5:0], 2'h0};
      default: return {s[3:0], 4'h0};
    endcase
  endfunction : sfo_shl

  // single line protocol answers on lane 1 only
  function automatic logic [3:0] sfo_emit(input logic [7:0] s, input sfo_proto_t p);
    unique case (p)
      PR_EXT: return {2'h0, s[7], 1'h0};
      PR_DUAL: return {2'h0, s[7:6]};
      default: return s[7:4];
    endcase
  endfunction : sfo_emit

  function automatic logic [3:0] sfo_oe(input sfo_proto_t p);
    unique case (p)
      PR_EXT: return 4'h2;
      PR_DUAL: return 4'h3;
      default: return 4'hf;
    endcase
  endfunction : sfo_oe

  // core side: flag byte and opcode hand-off
  always_comb begin
    logic [7:0] err;
    err = cq.flags & ERR_MASK;
    cd = cq;
    clr_now = 1'h0;
    cd.op_valid = 1'h0;
    cd.ack_s1 = hq.ack;
    cd.ack_s2 = cq.ack_s1;
    cd.tog_s1 = hq.tog;
    cd.tog_s2 = cq.tog_s1;
    cd.tog_s3 = cq.tog_s2;
    // link holds op stable until its next toggle, so reading it here is safe
    if (cq.tog_s2 != cq.tog_s3) begin
      cd.op_valid = 1'h1;
      cd.op_code = hq.op;
      clr_now = (hq.op == OP_CLR_FLAGS);
    end
    if (clr_now) begin
      err = '0;
    end
    // sets come after the clear so a same-cycle event survives
    err[F_EERR] = err[F_EERR] | erase_fail;
    err[F_PERR] = err[F_PERR] | prog_fail
                  | (prog_zero_to_one & accel_high_voltage & pattern_mult64);
    err[F_VPP] = err[F_VPP] | (vpp_invalid & wip);
    err[F_PROT] = err[F_PROT] | prot_sector_hit | otp_locked_hit;
    cd.flags = err;
    cd.flags[F_READY] = ~wip;
    cd.flags[F_ESUSP] = erase_susp;
    cd.flags[F_PSUSP] = prog_susp;
    cd.flags[F_ADDR4] = addr4_en;
    if (cq.req == cq.ack_s2) begin
      cd.snap = {proto_sel, cd.flags};
      cd.req = ~cq.req;
    end
    if (rst) begin
      cd.flags = FLAGS_RST;
      cd.snap = {PR_EXT, FLAGS_RST};
      // both handshake ends start from zero, so no unknown outlives reset
      cd.req = 1'h0;
      cd.ack_s1 = 1'h0;
      cd.ack_s2 = 1'h0;
      cd.tog_s1 = 1'h0;
      cd.tog_s2 = 1'h0;
      cd.tog_s3 = 1'h0;
      cd.op_code = '0;
      cd.op_valid = 1'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    cq <= cd;
  end

  assign flags = cq.flags;
  assign op_valid = cq.op_valid;
  assign op_code = cq.op_code;

  // link side: snapshot receiver and opcode toggle, reset by a synced rst
  always_comb begin
    hd = hq;
    hd.rst_s1 = rst;
    hd.rst_s2 = hq.rst_s1;
    hd.req_s1 = cq.req;
    hd.req_s2 = hq.req_s1;
    if (hq.req_s2 != hq.ack) begin
      hd.ack = ~hq.ack;
      {hd.proto, hd.flags} = cq.snap;
    end
    if (op_acc) begin
      hd.tog = ~hq.tog;
      hd.op = op_new;
    end
    if (hq.rst_s2) begin
      hd.req_s1 = 1'h0;
      hd.req_s2 = 1'h0;
      hd.ack = 1'h0;
      hd.proto = PR_EXT;
      hd.flags = FLAGS_RST;
      hd.tog = 1'h0;
      hd.op = '0;
    end
  end

  always_ff @(posedge spi_clk) begin
    hq <= hd;
  end

  // protocol follows proto_sel through the snapshots and may change on any link edge, even mid-frame
  assign pr = sfo_proto_t'(hq.proto);

  // frame logic: opcode capture, then flag stream or silence
  always_comb begin
    fd = fq;
    op_last = 1'h0;
    op_acc = 1'h0;
    op_new = sfo_shin(fq.sr, dq_in, pr);
    unique case (fq.phase)
      PH_OP: begin
        fd.sr = op_new;
        fd.cnt = fq.cnt + 3'h1;
        if (fq.cnt == sfo_last(pr)) begin
          op_last = 1'h1;
          fd.cnt = sfo_last(pr);
          if (!sfo_op_ok(op_new, pr)) begin
            fd.phase = PH_IGN;
          end else begin
            op_acc = 1'h1;
            if (op_new == OP_RD_FLAGS) begin
              fd.phase = PH_FLAG;
              fd.dout = sfo_emit(hq.flags, pr);
              fd.sr = sfo_shl(hq.flags, pr);
              fd.oe = sfo_oe(pr);
            end else begin
              fd.phase = PH_DONE;
            end
          end
        end
      end
      PH_FLAG: begin
        if (fq.cnt == 3'h0) begin
          fd.dout = sfo_emit(hq.flags, pr);
          fd.sr = sfo_shl(hq.flags, pr);
          fd.cnt = sfo_last(pr);
        end else begin
          fd.dout = sfo_emit(fq.sr, pr);
          fd.sr = sfo_shl(fq.sr, pr);
          fd.cnt = fq.cnt - 3'h1;
        end
      end
      PH_IGN, PH_DONE: begin
      end
    endcase
  end

  // chip select high ends the frame even though spi_clk has stopped
  always_ff @(posedge spi_clk or posedge cs_n) begin
    if (cs_n) begin
      fq <= FR_RST;
    end else begin
      fq <= fd;
    end
  end

  assign dq_out = fq.dout;
  assign dq_oe = fq.oe;

  a_ready_busy: assert property (@(posedge sys_clk) disable iff (rst)
    wip |=> !flags[F_READY]) else $error("ready flag set while busy");
  a_ready_inv: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(wip) |=> flags[F_READY] && $past(flags[F_READY]) == 1'h0)
    else $error("ready flag not inverse of busy");
  a_erase_susp: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 flags[F_ESUSP] == $past(erase_susp)) else $error("erase suspend flag wrong");
  a_prog_susp: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 flags[F_PSUSP] == $past(prog_susp)) else $error("program suspend flag wrong");
  a_addr_mode: assert property (@(posedge sys_clk) disable iff (rst)
    addr4_en ##1 addr4_en |-> flags[F_ADDR4]) else $error("address mode flag wrong");
  a_erase_err: assert property (@(posedge sys_clk) disable iff (rst)
    erase_fail |=> flags[F_EERR]) else $error("erase error not raised");
  a_prog_accel: assert property (@(posedge sys_clk) disable iff (rst)
    prog_zero_to_one && accel_high_voltage && pattern_mult64 |=> flags[F_PERR])
    else $error("program error not raised");
  a_vpp_err: assert property (@(posedge sys_clk) disable iff (rst)
    vpp_invalid && wip |=> flags[F_VPP]) else $error("supply error not raised");
  a_prot_err: assert property (@(posedge sys_clk) disable iff (rst)
    prot_sector_hit || otp_locked_hit |=> flags[F_PROT]) else $error("protection not raised");
  a_err_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    flags[F_EERR] && !clr_now |=> flags[F_EERR]) else $error("erase error lost");
  a_clear_cmd: assert property (@(posedge sys_clk) disable iff (rst)
    clr_now && !prog_fail && !prog_zero_to_one |=> !flags[F_PERR] && op_valid)
    else $error("clear command did not clear");
  a_ign_quiet: assert property (@(posedge spi_clk) disable iff (cs_n)
    fq.phase == PH_IGN |=> $stable(hq.tog) && dq_oe == 4'h0 && fq.phase == PH_IGN)
    else $error("ignored opcode had an effect");
  a_id_proto: assert property (@(posedge spi_clk) disable iff (cs_n)
    op_last && (op_new == OP_ID_B) && pr != PR_EXT |=> fq.phase == PH_IGN)
    else $error("identification accepted outside extended");
  a_dual_quad: assert property (@(posedge spi_clk) disable iff (cs_n)
    op_last && (op_new == OP_DIOFR) && pr == PR_QUAD |=> fq.phase == PH_IGN)
    else $error("dual read accepted in quad");
  a_quad_dual: assert property (@(posedge spi_clk) disable iff (cs_n)
    op_last && (op_new == OP_QIOFR) && pr == PR_DUAL |=> fq.phase == PH_IGN)
    else $error("quad read accepted in dual");
  a_mio_ext: assert property (@(posedge spi_clk) disable iff (cs_n)
    op_last && (op_new == OP_ID_MIO) && pr == PR_EXT |=> fq.phase == PH_IGN)
    else $error("multi line identification accepted in extended");
  a_dtr_dual: assert property (@(posedge spi_clk) disable iff (cs_n)
    op_last && (op_new == OP_DTR_DIOFR) && pr == PR_QUAD |=> fq.phase == PH_IGN)
    else $error("rate doubled dual read accepted in quad");
  a_dtr_quad: assert property (@(posedge spi_clk) disable iff (cs_n)
    op_last && (op_new == OP_DTR_QOFR) && pr == PR_DUAL |=> fq.phase == PH_IGN)
    else $error("rate doubled quad read accepted in dual");
  a_addr4_dual: assert property (@(posedge spi_clk) disable iff (cs_n)
    op_last && (op_new == OP_4B_DOFR) && pr == PR_QUAD |=> fq.phase == PH_IGN)
    else $error("four byte dual read accepted in quad");
  a_addr4_quad: assert property (@(posedge spi_clk) disable iff (cs_n)
    op_last && (op_new == OP_4B_QIOFR) && pr == PR_DUAL |=> fq.phase == PH_IGN)
    else $error("four byte quad read accepted in dual");
  a_set_wins: assert property (@(posedge sys_clk) disable iff (rst)
    clr_now && erase_fail |=> flags[F_EERR]) else $error("clear beat a same cycle error");
  a_flag_out: assert property (@(posedge spi_clk) disable iff (cs_n)
    op_last && op_new == OP_RD_FLAGS |=> fq.phase == PH_FLAG && dq_oe == sfo_oe(pr))
    else $error("flag read did not stream");

  c_flag_read: cover property (@(posedge spi_clk) disable iff (cs_n)
    fq.phase == PH_FLAG && fq.cnt == 3'h0);
  c_ignored: cover property (@(posedge spi_clk) disable iff (cs_n) fq.phase == PH_IGN);
  c_clear: cover property (@(posedge sys_clk) disable iff (rst)
    clr_now && flags[F_EERR]);
  c_set_clear: cover property (@(posedge sys_clk) disable iff (rst) clr_now && erase_fail);

endmodule : sfo_flag_ctl
`default_nettype wire

// >>> sfo_host_model.sv
// Purpose: host controller model on the serial link of the flag block
// Assumes: mode 0 framing; host changes its lines after the falling edge
// Notes: link clock parks low between frames; idle data lines show inverted values
`default_nettype none
module sfo_host_model (
  output logic spi_clk, // link clock
  output logic cs_n, // chip select, low active
  output logic [3:0] dq_in, // lines towards the device
  input wire logic [3:0] dq_out, // lines from the device
  input wire logic [3:0] dq_oe // device line enables
);
  timeunit 1ns;
  timeprecision 100ps;
  // set before any process starts, so an early idle call is never undone
  logic run = 1'b0;
  initial begin
    spi_clk = 1'b0;
    cs_n = 1'b1;
    dq_in = 4'h5;
  end
  // odd start offset keeps the link phase unrelated to the core clock
  initial begin
    #1.3;
    forever begin
      #3;
      if (run || spi_clk) spi_clk <= ~spi_clk;
    end
  end
  // clocks with chip select high, used for reset and snapshot transfer
  task automatic idle(input int n);
    run = 1'b1;
    repeat (n) @(posedge spi_clk);
    @(negedge spi_clk);
    run = 1'b0;
    dq_in = ~dq_in;
  endtask : idle
  // one frame: opcode msb first, then nrd bytes read back on the answer lanes
  task automatic frame(input logic [7:0] op, input logic [1:0] pr, input int nrd,
                       output logic [15:0] rd, output logic [3:0] oe);
    int w;
    logic [7:0] sh;
    logic [3:0] v;
    w = (pr == 2'h0) ? 1 : (pr == 2'h1) ? 2 : 4;
    sh = op;
    rd = '0;
    oe = '0;
    cs_n = 1'b0;
    for (int i = 0; i < 8 / w; i++) begin
      if (w == 1) dq_in = {~dq_in[3:1], sh[7]};
      else if (w == 2) dq_in = {~dq_in[3:2], sh[7:6]};
      else dq_in = sh[7:4];
      sh = sh << w;
      run = 1'b1;
      @(posedge spi_clk);
      @(negedge spi_clk);
    end
    for (int i = 0; i < nrd * 8 / w; i++) begin
      dq_in = ~dq_in;
      @(posedge spi_clk);
      oe = oe | dq_oe;
      // an undriven lane reads back inverted rather than holding its last value
      v = (dq_out & dq_oe) | (~dq_out & ~dq_oe);
      if (w == 1) rd = {rd[14:0], v[1]};
      else if (w == 2) rd = {rd[13:0], v[1:0]};
      else rd = {rd[11:0], v};
      @(negedge spi_clk);
    end
    cs_n = 1'b1;
    dq_in = ~dq_in;
    run = 1'b0;
  endtask : frame
endmodule : sfo_host_model
`default_nettype wire

// >>> sfo_pkg.sv
// Purpose: shared constants and types for the flash opcode and flag block
// Assumes: one byte opcode per frame, flag byte sent msb first
// Notes: flag layout, reset value and opcode codes live here; the bench also repeats them as literals
`default_nettype none
package sfo_pkg;

  // flag byte bit positions
  localparam int unsigned F_READY = 7;
  localparam int unsigned F_ESUSP = 6;
  localparam int unsigned F_EERR = 5;
  localparam int unsigned F_PERR = 4;
  localparam int unsigned F_VPP = 3;
  localparam int unsigned F_PSUSP = 2;
  localparam int unsigned F_PROT = 1;
  localparam int unsigned F_ADDR4 = 0;

  localparam logic [7:0] FLAGS_RST = 8'h80;
  localparam logic [7:0] ERR_MASK = 8'h3a;

  // opcodes
  localparam logic [7:0] OP_RD_FLAGS = 8'h70;
  localparam logic [7:0] OP_CLR_FLAGS = 8'h50;
  localparam logic [7:0] OP_ID_A = 8'h9e;
  localparam logic [7:0] OP_ID_B = 8'h9f;
  localparam logic [7:0] OP_ID_MIO = 8'haf;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_DOFR = 8'h3b;
  localparam logic [7:0] OP_DIOFR = 8'hbb;
  localparam logic [7:0] OP_QOFR = 8'h6b;
  localparam logic [7:0] OP_QIOFR = 8'heb;
  localparam logic [7:0] OP_DTR_FR = 8'h0d;
  localparam logic [7:0] OP_DTR_DOFR = 8'h3d;
  localparam logic [7:0] OP_DTR_DIOFR = 8'hbd;
  localparam logic [7:0] OP_DTR_QOFR = 8'h6d;
  localparam logic [7:0] OP_DTR_QIOFR = 8'hed;
  localparam logic [7:0] OP_4B_DOFR = 8'h3c;
  localparam logic [7:0] OP_4B_DIOFR = 8'hbc;
  localparam logic [7:0] OP_4B_QOFR = 8'h6c;
  localparam logic [7:0] OP_4B_QIOFR = 8'hec;
  localparam logic [7:0] OP_DPROG = 8'ha2;
  localparam logic [7:0] OP_XDPROG = 8'hd2;
  localparam logic [7:0] OP_QPROG = 8'h32;
  localparam logic [7:0] OP_4B_QPROG = 8'h34;
  localparam logic [7:0] OP_XQPROG = 8'h38;

  typedef enum logic [1:0] {
    PR_EXT = 2'h0,
    PR_DUAL = 2'h1,
    PR_QUAD = 2'h2
  } sfo_proto_t;

  typedef enum logic [1:0] {
    PH_OP = 2'h0,
    PH_FLAG = 2'h1,
    PH_IGN = 2'h3,
    PH_DONE = 2'h2
  } sfo_phase_t;

endpackage : sfo_pkg
`default_nettype wire

// >>> test_serial_flash_opcode_and_flags.sv
// Purpose: self-checking bench for opcode acceptance and the flag byte
// Assumes: core inputs change on sys_clk rise; link driven by the host model
// Notes: every frame is preceded by idle link clocks so snapshots can cross
`default_nettype none
module test_serial_flash_opcode_and_flags;
  import sfo_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, rst, wip, erase_susp, prog_susp, addr4_en;
  logic erase_fail, prog_fail, prog_zero_to_one, accel_high_voltage, pattern_mult64;
  logic vpp_invalid, prot_sector_hit, otp_locked_hit, op_valid, spi_clk, cs_n;
  logic [1:0] proto_sel;
  logic [7:0] flags, op_code, last_op;
  logic [3:0] dq_in, dq_out, dq_oe;
  int fail_count, check_count, ov_cnt;
  // event pattern: erase, prog, zero-to-one, accel, mult64, vpp, sector, otp, wip
  localparam logic [8:0] EV [8] = '{9'h100, 9'h080, 9'h070, 9'h050, 9'h009, 9'h008,
                                    9'h004, 9'h002};
  localparam logic [7:0] EV_EXP [8] = '{8'h20, 8'h10, 8'h10, 8'h00, 8'h08, 8'h00,
                                        8'h02, 8'h02};
  // opcode and accept mask {extended, dual, quad}
  localparam logic [10:0] DEC [16] = '{{8'h9e, 3'h4}, {8'h9f, 3'h4}, {8'haf, 3'h3},
    {8'h3b, 3'h6}, {8'hbb, 3'h6}, {8'h6b, 3'h5}, {8'heb, 3'h5}, {8'h0d, 3'h7},
    {8'h3d, 3'h6}, {8'hbd, 3'h6}, {8'h6d, 3'h5}, {8'hed, 3'h5}, {8'h3c, 3'h6},
    {8'hbc, 3'h6}, {8'h6c, 3'h5}, {8'hec, 3'h5}};
  localparam logic [3:0] LANES [3] = '{4'h2, 4'h3, 4'hf};

  sfo_flag_ctl uut (.sys_clk(sys_clk), .rst(rst), .wip(wip), .erase_susp(erase_susp),
    .prog_susp(prog_susp), .addr4_en(addr4_en), .proto_sel(proto_sel),
    .erase_fail(erase_fail), .prog_fail(prog_fail), .prog_zero_to_one(prog_zero_to_one),
    .accel_high_voltage(accel_high_voltage), .pattern_mult64(pattern_mult64),
    .vpp_invalid(vpp_invalid), .prot_sector_hit(prot_sector_hit),
    .otp_locked_hit(otp_locked_hit), .flags(flags), .op_valid(op_valid),
    .op_code(op_code), .spi_clk(spi_clk), .cs_n(cs_n), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe));
  sfo_host_model host (.spi_clk(spi_clk), .cs_n(cs_n), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe));

  always #5 sys_clk = ~sys_clk;
  // op_valid is a single-cycle pulse, so it is counted on every core edge
  always @(posedge sys_clk) begin
    if (op_valid === 1'b1) begin
      ov_cnt <= ov_cnt + 1;
      last_op <= op_code;
    end
  end

  task automatic test_done;
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic syc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : syc
  task automatic set_proto(input logic [1:0] pr);
    @(posedge sys_clk);
    proto_sel <= pr;
    host.idle(12);
    syc(2);
  endtask : set_proto
  task automatic send(input logic [7:0] op, input logic [1:0] pr, input bit acc);
    int c0;
    logic [15:0] rd;
    logic [3:0] oe;
    set_proto(pr);
    c0 = ov_cnt;
    host.frame(op, pr, 1, rd, oe);
    for (int i = 0; i < 16 && ov_cnt == c0; i++)
      syc(1);
    chk("op_valid", {15'h0, acc}, {15'h0, ov_cnt != c0});
    if (acc) chk("op_code", {8'h0, op}, {8'h0, last_op});
    else chk("dq_oe refused", 16'h0, {12'h0, oe});
  endtask : send

  task automatic t_reset;
    logic [15:0] rd;
    logic [3:0] oe;
    chk("flags reset", 16'h0080, {8'h0, flags});
    set_proto(2'h0);
    host.frame(OP_RD_FLAGS, 2'h0, 1, rd, oe);
    chk("flag read", 16'h0080, rd);
    chk("dq_oe ext", 16'h0002, {12'h0, oe});
  endtask : t_reset
  task automatic t_status;
    logic [15:0] rd;
    logic [3:0] oe;
    @(posedge sys_clk);
    {wip, erase_susp, prog_susp, addr4_en} <= 4'hf;
    syc(2);
    chk("flags status", 16'h0045, {8'h0, flags});
    for (int p = 0; p < 3; p++) begin
      set_proto(p[1:0]);
      host.frame(OP_RD_FLAGS, p[1:0], 2, rd, oe);
      chk("flag stream", 16'h4545, rd);
      chk("answer lanes", {12'h0, LANES[p]}, {12'h0, oe});
    end
    @(posedge sys_clk);
    {wip, erase_susp, prog_susp, addr4_en} <= 4'h0;
    syc(2);
    chk("flags idle", 16'h0080, {8'h0, flags});
  endtask : t_status
  task automatic t_errors;
    for (int k = 0; k < 8; k++) begin
      @(posedge sys_clk);
      {erase_fail, prog_fail, prog_zero_to_one, accel_high_voltage, pattern_mult64,
       vpp_invalid, prot_sector_hit, otp_locked_hit, wip} <= EV[k];
      @(posedge sys_clk);
      {erase_fail, prog_fail, prog_zero_to_one, accel_high_voltage, pattern_mult64,
       vpp_invalid, prot_sector_hit, otp_locked_hit, wip} <= 9'h000;
      syc(6);
      chk("error sticky", {8'h0, 8'h80 | EV_EXP[k]}, {8'h0, flags});
      send(OP_CLR_FLAGS, 2'(k % 3), 1'b1);
      syc(2);
      chk("flags cleared", 16'h0080, {8'h0, flags});
    end
    // an error still present during the clear survives it
    @(posedge sys_clk);
    erase_fail <= 1'b1;
    send(OP_CLR_FLAGS, 2'h0, 1'b1);
    syc(2);
    chk("error over clear", 16'h00a0, {8'h0, flags});
    @(posedge sys_clk);
    erase_fail <= 1'b0;
    send(OP_CLR_FLAGS, 2'h0, 1'b1);
    syc(2);
    chk("flags cleared", 16'h0080, {8'h0, flags});
  endtask : t_errors
  task automatic t_decode;
    for (int p = 0; p < 3; p++) begin
      for (int j = 0; j < 16; j++)
        send(DEC[j][10:3], p[1:0], DEC[j][2 - p]);
    end
    chk("flags after refusals", 16'h0080, {8'h0, flags});
  endtask : t_decode

  initial begin
    #200000;
    fail_count++;
    test_done();
  end
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    proto_sel = 2'h0;
    {erase_fail, prog_fail, prog_zero_to_one, accel_high_voltage, pattern_mult64,
     vpp_invalid, prot_sector_hit, otp_locked_hit, wip} = 9'h000;
    {erase_susp, prog_susp, addr4_en} = 3'h0;
    fail_count = 0;
    check_count = 0;
    ov_cnt = 0;
    last_op = 8'h00;
    // five link clocks finish before reset drops, so the two idle calls never overlap
    fork
      host.idle(5);
    join_none
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    host.idle(6);
    syc(10);
    t_reset();
    t_status();
    t_errors();
    t_decode();
    test_done();
  end
endmodule : test_serial_flash_opcode_and_flags
`default_nettype wire
